/* rtl/bsc_bank_switch_map.svh */
`ifndef BSC_BANK_SWITCH_MAP_SVH
`define BSC_BANK_SWITCH_MAP_SVH

// Control register index and its AHB byte address (four times the index)
`define BSC_CTRL_IDX      8'h29
`define BSC_CTRL_ADDR     {22'h000000, `BSC_CTRL_IDX, 2'h0}

// Control register reset value and writable bits
`define BSC_CTRL_RESET    16'hf000
`define BSC_CTRL_WMASK    16'hf006

// Control register field positions
`define BSC_CONSECUTIVE_SWITCH_MODE_BIT    15
`define BSC_DIV_MSB       14
`define BSC_DIV_LSB       13
`define BSC_INTERRUPT_ACKNOWLEDGE_OUT_OFF_BIT  12
`define BSC_HD_KEEP_BIT   2
`define BSC_EXT_KEEP_BIT  1

// Bank of 32K words: address bits above bit 14 select the bank
`define BSC_BANK_MSB      17
`define BSC_BANK_LSB      15

// I/O space has 64K port addresses
`define BSC_IO_ADDR_MSB   15

// AHB transfer type that starts a single transfer
`define BSC_HTRANS_NONSEQ 2'h2

`endif

/* rtl/bsc_pkg.sv */
package bsc_pkg;

	// Address space of an external access
	typedef enum logic [1:0] {BSC_SP_PROG, BSC_SP_DATA, BSC_SP_IO} bsc_space_t;

	// External cycle sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_STROBE, ST_TRAIL} bsc_state_t;

endpackage : bsc_pkg

/* rtl/bsc_div_if.sv */
`timescale 1ns/1ns
// Divide factor out to the divider, output clock tick and level back
interface bsc_div_if;
	logic [1:0] div_factor;
	logic       tick;
	logic       clk_level;

	modport ctrl (output div_factor, input tick, input clk_level);
	modport gen  (input div_factor, output tick, output clk_level);
endinterface : bsc_div_if

/* rtl/bsc_clock_divider.sv */
`timescale 1ns/1ns
`include "bsc_bank_switch_map.svh"
module bsc_clock_divider (
	input  wire logic i_clk,
	input  wire logic i_rst,
	bsc_div_if.gen    div_port
);
	import bsc_pkg::*;

	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic       lvl_reg;
	logic       lvl_next;
	logic [2:0] half;

	// Phase counter wraps at the divide factor; a lowered factor wraps at once
	always_comb
	begin
		half     = 3'((({1'b0, div_port.div_factor}) + 3'h1) >> 1);
		cnt_next = (cnt_reg >= div_port.div_factor) ? 2'h0 : 2'(cnt_reg + 2'h1);
		lvl_next = (div_port.div_factor == 2'h0) ? 1'b1 : ({1'b0, cnt_next} < half);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_reg <= 2'h0;
			lvl_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_next;
			lvl_reg <= lvl_next;
		end
	end

	// One tick per output clock period
	assign div_port.tick      = (cnt_reg >= div_port.div_factor);
	assign div_port.clk_level = lvl_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	div_four_a: assert property ((div_port.tick && div_port.div_factor == 2'h3) ##1 (div_port.div_factor == 2'h3)[*4]
		|-> div_port.tick && !$past(div_port.tick) && !$past(div_port.tick, 2) && !$past(div_port.tick, 3))
		else $error("output clock period is not four system clocks");
	div_two_a: assert property ((div_port.tick && div_port.div_factor == 2'h1) ##1 (div_port.div_factor == 2'h1)[*2]
		|-> div_port.tick && !$past(div_port.tick))
		else $error("output clock period is not two system clocks");
	div_three_c: cover property (div_port.div_factor == 2'h2 && div_port.tick);

endmodule : bsc_clock_divider

/* rtl/bsc_bank_switch_ctrl.sv */
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "bsc_bank_switch_map.svh"
module bsc_bank_switch_ctrl (
	input  wire logic              I_SYS_CLK,
	input  wire logic              I_RST,
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	output logic [31:0]            HRDATA,
	input  wire logic              I_ACC_REQ,
	input  wire bsc_pkg::bsc_space_t I_ACC_SPACE,
	input  wire logic              I_ACC_WRITE,
	input  wire logic [17:0]       I_ACC_ADDR,
	input  wire logic [15:0]       I_ACC_WDATA,
	output logic                   O_ACC_DONE,
	output logic [15:0]            O_ACC_RDATA,
	output logic [17:0]            O_ADDR,
	output logic [15:0]            O_DATA_OUT,
	output logic                   O_DATA_OE,
	input  wire logic [15:0]       I_DATA_IN,
	output logic                   O_READ_NOT_WRITE,
	output logic                   O_MEMORY_STROBE_N,
	output logic                   O_IO_SPACE_STROBE_N,
	output logic                   O_OUTPUT_CLOCK,
	input  wire logic              I_INT_ACK,
	output logic                   O_INTERRUPT_ACKNOWLEDGE_OUT_N,
	input  wire logic              I_HOST_PORT_WIDE_STRAP,
	output logic                   O_ADDR_KEEPER_EN,
	output logic                   O_DATA_KEEPER_EN,
	output logic                   O_HOST_DATA_KEEPER_EN
);
	import bsc_pkg::*;

	bsc_div_if div_bus ();

	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic [31:0] rdata_next;
	logic        ahb_take;
	logic        ctrl_hit;

	bsc_state_t  state_reg;
	bsc_state_t  state_next;
	logic [2:0]  last_bank_reg;
	logic [2:0]  last_bank_next;
	bsc_space_t  last_space_reg;
	bsc_space_t  last_space_next;
	logic        cur_read_reg;
	logic        cur_read_next;
	logic        cur_mem_reg;
	logic        cur_mem_next;
	logic [17:0] addr_next;
	logic [15:0] dout_next;
	logic        oe_next;
	logic        rnw_next;
	logic        memory_strobe_n_n_next;
	logic        istrb_n_next;
	logic        done_next;
	logic [15:0] acc_rdata_next;
	logic        accept;
	logic        bank_change;
	logic        need_gap;
	logic        consecutive_switch_mode;
	logic [2:0]  keep_bits;

	// Program and data space go through the memory strobe, I/O space does not
	function automatic logic is_mem(input bsc_space_t sp);
		is_mem = (sp != BSC_SP_IO);
	endfunction : is_mem

	// Keeper decode: address, data, host data enables; address lines hold only in wide host mode
	function automatic logic [2:0] keeper_map(input logic [15:0] ctrl, input logic strap);
		keeper_map = {ctrl[`BSC_HD_KEEP_BIT] & strap, ctrl[`BSC_EXT_KEEP_BIT], ctrl[`BSC_HD_KEEP_BIT] | strap};
	endfunction : keeper_map

	bsc_clock_divider u_divider (
		.i_clk    (I_SYS_CLK),
		.i_rst    (I_RST),
		.div_port (div_bus.gen)
	);

	assign div_bus.div_factor = ctrl_reg[`BSC_DIV_MSB:`BSC_DIV_LSB];
	assign consecutive_switch_mode             = ctrl_reg[`BSC_CONSECUTIVE_SWITCH_MODE_BIT];

	// AHB-Lite slave: zero wait states, always OKAY, one register
	assign ahb_take = HSEL && HREADY && (HTRANS == `BSC_HTRANS_NONSEQ);
	assign ctrl_hit = (HADDR == `BSC_CTRL_ADDR);

	always_comb
	begin
		wr_pend_next = ahb_take && HWRITE && ctrl_hit;
		rdata_next   = HRDATA;
		if (ahb_take && !HWRITE)
			rdata_next = ctrl_hit ? {16'h0000, ctrl_reg} : 32'h00000000;
		ctrl_next = ctrl_reg;
		if (wr_pend_reg)
			ctrl_next = HWDATA[15:0] & `BSC_CTRL_WMASK;
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			ctrl_reg    <= `BSC_CTRL_RESET;
			wr_pend_reg <= 1'b0;
			HRDATA      <= 32'h00000000;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			wr_pend_reg <= wr_pend_next;
			HRDATA      <= rdata_next;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end
	end

	// Bank or space change against the stored last memory access
	assign accept      = (state_reg == ST_IDLE) && div_bus.tick && I_ACC_REQ && !O_ACC_DONE;
	assign bank_change = (I_ACC_ADDR[`BSC_BANK_MSB:`BSC_BANK_LSB] != last_bank_reg)
		|| (I_ACC_SPACE != last_space_reg);
	assign need_gap    = is_mem(I_ACC_SPACE) && !I_ACC_WRITE && (consecutive_switch_mode || bank_change);

	// External cycle sequencer, stepped once per output clock period
	always_comb
	begin
		state_next      = state_reg;
		last_bank_next  = last_bank_reg;
		last_space_next = last_space_reg;
		cur_read_next   = cur_read_reg;
		cur_mem_next    = cur_mem_reg;
		addr_next       = O_ADDR;
		dout_next       = O_DATA_OUT;
		oe_next         = O_DATA_OE;
		rnw_next        = O_READ_NOT_WRITE;
		memory_strobe_n_n_next    = O_MEMORY_STROBE_N;
		istrb_n_next    = O_IO_SPACE_STROBE_N;
		done_next       = 1'b0;
		acc_rdata_next  = O_ACC_RDATA;
		case (state_reg)
			ST_IDLE:
			begin
				if (accept)
				begin
					cur_read_next = !I_ACC_WRITE;
					cur_mem_next  = is_mem(I_ACC_SPACE);
					rnw_next      = !I_ACC_WRITE;
					dout_next     = I_ACC_WDATA;
					oe_next       = I_ACC_WRITE;
					if (is_mem(I_ACC_SPACE))
					begin
						addr_next       = I_ACC_ADDR;
						last_bank_next  = I_ACC_ADDR[`BSC_BANK_MSB:`BSC_BANK_LSB];
						last_space_next = I_ACC_SPACE;
					end
					else
						addr_next = {2'h0, I_ACC_ADDR[`BSC_IO_ADDR_MSB:0]};
					if (need_gap)
						state_next = ST_GAP;
					else
					begin
						state_next   = ST_STROBE;
						memory_strobe_n_n_next = !is_mem(I_ACC_SPACE);
						istrb_n_next = is_mem(I_ACC_SPACE);
					end
				end
			end
			ST_GAP:
			begin
				if (div_bus.tick)
				begin
					state_next   = ST_STROBE;
					memory_strobe_n_n_next = 1'b0;
				end
			end
			ST_STROBE:
			begin
				if (div_bus.tick)
				begin
					memory_strobe_n_n_next = 1'b1;
					istrb_n_next = 1'b1;
					oe_next      = 1'b0;
					if (cur_read_reg)
						acc_rdata_next = I_DATA_IN;
					if (consecutive_switch_mode && cur_read_reg && cur_mem_reg)
						state_next = ST_TRAIL;
					else
					begin
						state_next = ST_IDLE;
						done_next  = 1'b1;
					end
				end
			end
			ST_TRAIL:
			begin
				if (div_bus.tick)
				begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			state_reg           <= ST_IDLE;
			last_bank_reg       <= 3'h0;
			last_space_reg      <= BSC_SP_PROG;
			cur_read_reg        <= 1'b0;
			cur_mem_reg         <= 1'b0;
			O_ADDR              <= 18'h00000;
			O_DATA_OUT          <= 16'h0000;
			O_DATA_OE           <= 1'b0;
			O_READ_NOT_WRITE    <= 1'b1;
			O_MEMORY_STROBE_N   <= 1'b1;
			O_IO_SPACE_STROBE_N <= 1'b1;
			O_ACC_DONE          <= 1'b0;
			O_ACC_RDATA         <= 16'h0000;
		end
		else
		begin
			state_reg           <= state_next;
			last_bank_reg       <= last_bank_next;
			last_space_reg      <= last_space_next;
			cur_read_reg        <= cur_read_next;
			cur_mem_reg         <= cur_mem_next;
			O_ADDR              <= addr_next;
			O_DATA_OUT          <= dout_next;
			O_DATA_OE           <= oe_next;
			O_READ_NOT_WRITE    <= rnw_next;
			O_MEMORY_STROBE_N   <= memory_strobe_n_n_next;
			O_IO_SPACE_STROBE_N <= istrb_n_next;
			O_ACC_DONE          <= done_next;
			O_ACC_RDATA         <= acc_rdata_next;
		end
	end

	// Registered pin controls: clock, acknowledge gating, keepers
	assign keep_bits = keeper_map(ctrl_reg, I_HOST_PORT_WIDE_STRAP);

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			O_OUTPUT_CLOCK                <= 1'b1;
			O_INTERRUPT_ACKNOWLEDGE_OUT_N <= 1'b1;
			O_ADDR_KEEPER_EN              <= 1'b0;
			O_DATA_KEEPER_EN              <= 1'b0;
			O_HOST_DATA_KEEPER_EN         <= 1'b0;
		end
		else
		begin
			O_OUTPUT_CLOCK                <= div_bus.clk_level;
			O_INTERRUPT_ACKNOWLEDGE_OUT_N <= !(I_INT_ACK && !ctrl_reg[`BSC_INTERRUPT_ACKNOWLEDGE_OUT_OFF_BIT]);
			O_ADDR_KEEPER_EN              <= keep_bits[2];
			O_DATA_KEEPER_EN              <= keep_bits[1];
			O_HOST_DATA_KEEPER_EN         <= keep_bits[0];
		end
	end

	default clocking mcb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);

	gap_on_switch_a: assert property (accept && is_mem(I_ACC_SPACE) && !I_ACC_WRITE && bank_change
		|=> state_reg == ST_GAP && O_MEMORY_STROBE_N)
		else $error("bank change read did not start with an idle cycle");
	same_bank_a: assert property (accept && is_mem(I_ACC_SPACE) && !I_ACC_WRITE && !bank_change && !consecutive_switch_mode
		|=> state_reg == ST_STROBE && !O_MEMORY_STROBE_N)
		else $error("same bank read was delayed");
	consecutive_switch_mode_trail_a: assert property (state_reg == ST_STROBE && div_bus.tick && consecutive_switch_mode && cur_read_reg && cur_mem_reg
		|=> state_reg == ST_TRAIL && O_MEMORY_STROBE_N && !O_ACC_DONE)
		else $error("consecutive mode read lacks its trailing cycle");
	last_bank_a: assert property (accept && is_mem(I_ACC_SPACE)
		|=> last_bank_reg == $past(I_ACC_ADDR[`BSC_BANK_MSB:`BSC_BANK_LSB]) && last_space_reg == $past(I_ACC_SPACE))
		else $error("stored bank not updated");
	io_strobe_a: assert property (!O_IO_SPACE_STROBE_N |-> O_MEMORY_STROBE_N && !cur_mem_reg
		&& O_ADDR[17:16] == 2'h0)
		else $error("I/O strobe overlaps memory strobe");
	reserved_zero_a: assert property ((ctrl_reg & ~`BSC_CTRL_WMASK) == 16'h0000)
		else $error("reserved control bits are not zero");
	ctrl_read_a: assert property (ahb_take && !HWRITE && ctrl_hit && !wr_pend_reg
		|=> HRDATA == {16'h0000, ctrl_reg} && HREADYOUT && !HRESP)
		else $error("control register read returned wrong data");
	ctrl_write_a: assert property (wr_pend_reg |=> ctrl_reg == ($past(HWDATA[15:0]) & `BSC_CTRL_WMASK))
		else $error("control register write not stored");
	interrupt_acknowledge_out_off_a: assert property (!O_INTERRUPT_ACKNOWLEDGE_OUT_N |-> !$past(ctrl_reg[`BSC_INTERRUPT_ACKNOWLEDGE_OUT_OFF_BIT])
		&& $past(I_INT_ACK))
		else $error("interrupt acknowledge passed while suppressed");
	keeper_a: assert property (##1 O_HOST_DATA_KEEPER_EN == $past(ctrl_reg[`BSC_HD_KEEP_BIT] | I_HOST_PORT_WIDE_STRAP)
		&& O_DATA_KEEPER_EN == $past(ctrl_reg[`BSC_EXT_KEEP_BIT])
		&& O_ADDR_KEEPER_EN == $past(ctrl_reg[`BSC_HD_KEEP_BIT] & I_HOST_PORT_WIDE_STRAP))
		else $error("keeper enables do not follow control bits");

	gap_read_c: cover property (state_reg == ST_GAP ##[1:8] state_reg == ST_STROBE);
	trail_read_c: cover property (state_reg == ST_TRAIL ##[1:8] O_ACC_DONE);
	io_write_c: cover property (!O_IO_SPACE_STROBE_N && O_DATA_OE);

endmodule : bsc_bank_switch_ctrl

/* tb/bsc_ext_mem_model.sv */
`timescale 1ns/1ns
module bsc_ext_mem_model (
	input  wire logic        i_clk,
	input  wire logic [17:0] i_addr,
	input  wire logic [15:0] i_data_out,
	input  wire logic        i_data_oe,
	input  wire logic        i_read_not_write,
	input  wire logic        i_memory_strobe_n,
	input  wire logic        i_io_space_strobe_n,
	output logic [15:0]      o_data_in,
	output logic [15:0]      o_last_wdata
);
	logic        mem_sel;
	logic        io_sel;
	logic [15:0] last_reg = 16'h0000;
	// Decode memory and port cycles from the two strobes
	assign mem_sel = !i_memory_strobe_n;
	assign io_sel  = !i_io_space_strobe_n;
	// Answer a read; released bus shows a level that toggles every cycle
	assign o_data_in = (i_read_not_write && mem_sel) ? (i_addr[15:0] ^ 16'h5a5a) :
		(i_read_not_write && io_sel) ? (i_addr[15:0] ^ 16'hc3c3) : ~last_reg;
	// Track the bus level and capture written words
	always @(posedge i_clk)
	begin
		last_reg <= o_data_in;
		if ((mem_sel || io_sel) && i_data_oe && !i_read_not_write)
			o_last_wdata <= i_data_out;
	end
endmodule : bsc_ext_mem_model

/* tb/bank_switch_bus_control_tb.sv */
`timescale 1ns/1ns
`include "bsc_bank_switch_map.svh"
module bank_switch_bus_control_tb;
	import bsc_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, req = 1'b0, acc_wr = 1'b0;
	logic        int_ack = 1'b0, strap = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h9744ab35;
	logic [1:0]  htrans = 2'h0;
	bsc_space_t  space = BSC_SP_PROG, last_sp = BSC_SP_PROG;
	logic [17:0] acc_addr = 18'h0, o_addr;
	logic [15:0] acc_wdata = 16'h0, rdata, dout, din, last_wd, ctrl;
	logic [2:0]  last_bank = 3'h0;
	logic        hreadyout, hresp, done, oe, rnw, memory_strobe_n_n, istrb_n, oclk, interrupt_acknowledge_out_n, akeep, dkeep, hkeep;
	int          miscompares = 0, comparisons = 0, cycles = 0, n;
	// Clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic chk_rng(input string s, input int lo, input int hi, input int g);
		comparisons++;
		if (g < lo || g > hi)
		begin
			miscompares++;
			$display("Error %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask : chk_rng
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction : lfsr
	// One AHB single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= `BSC_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk("bus response", 32'h0, {31'h0, hresp});
	endtask : ahb
	task automatic wreg(input logic [15:0] d);
		ahb(1'b1, `BSC_CTRL_ADDR, {16'h0, d}, rd);
		ctrl = d & 16'hf006;
	endtask : wreg
	// One core access with timing, strobe, bus and data checks
	task automatic acc(input bsc_space_t sp, input logic w, input logic [17:0] a, input logic [15:0] d);
		int k, lo, p, lows, ios;
		logic gap, io, bad;
		logic [17:0] ea;
		p = ctrl[14:13] + 1;
		io = (sp == BSC_SP_IO);
		ea = io ? {2'h0, a[15:0]} : a;
		gap = !w && !io && (ctrl[15] || sp != last_sp || a[17:15] != last_bank);
		lo = p + 2 + (gap ? p : 0) + ((!w && !io && ctrl[15]) ? p : 0);
		k = 0;
		lows = 0;
		ios = 0;
		bad = 1'b0;
		@(posedge clk);
		req <= 1'b1;
		space <= sp;
		acc_wr <= w;
		acc_addr <= a;
		acc_wdata <= d;
		do
		begin
			@(posedge clk);
			k++;
			lows += !memory_strobe_n_n;
			ios += !istrb_n;
			if (!memory_strobe_n_n || !istrb_n)
				bad |= (o_addr !== ea) || (rnw !== !w) || (oe !== w);
		end
		while (done !== 1'b1);
		req <= 1'b0;
		chk_rng("access cycles", lo, lo + p, k);
		chk("memory strobe cycles", io ? 0 : p, lows);
		chk("io strobe cycles", io ? p : 0, ios);
		chk("bus during strobe", 32'h0, {31'h0, bad});
		if (!w)
			chk("read data", {16'h0, a[15:0] ^ (io ? 16'hc3c3 : 16'h5a5a)}, {16'h0, rdata});
		else
			chk("write data", {16'h0, d}, {16'h0, last_wd});
		if (!io)
		begin
			last_sp = sp;
			last_bank = a[17:15];
		end
	endtask : acc
	bsc_bank_switch_ctrl uut (
		.I_SYS_CLK(clk), .I_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
		.HRDATA(hrdata), .I_ACC_REQ(req), .I_ACC_SPACE(space), .I_ACC_WRITE(acc_wr), .I_ACC_ADDR(acc_addr),
		.I_ACC_WDATA(acc_wdata), .O_ACC_DONE(done), .O_ACC_RDATA(rdata), .O_ADDR(o_addr),
		.O_DATA_OUT(dout), .O_DATA_OE(oe), .I_DATA_IN(din), .O_READ_NOT_WRITE(rnw),
		.O_MEMORY_STROBE_N(memory_strobe_n_n), .O_IO_SPACE_STROBE_N(istrb_n), .O_OUTPUT_CLOCK(oclk),
		.I_INT_ACK(int_ack), .O_INTERRUPT_ACKNOWLEDGE_OUT_N(interrupt_acknowledge_out_n), .I_HOST_PORT_WIDE_STRAP(strap),
		.O_ADDR_KEEPER_EN(akeep), .O_DATA_KEEPER_EN(dkeep), .O_HOST_DATA_KEEPER_EN(hkeep)
	);
	bsc_ext_mem_model u_mem (
		.i_clk(clk), .i_addr(o_addr), .i_data_out(dout), .i_data_oe(oe), .i_read_not_write(rnw),
		.i_memory_strobe_n(memory_strobe_n_n), .i_io_space_strobe_n(istrb_n), .o_data_in(din), .o_last_wdata(last_wd)
	);
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("idle strobes and keepers", 32'hc, {28'h0, memory_strobe_n_n, istrb_n, akeep, dkeep});
		ahb(1'b0, `BSC_CTRL_ADDR, 32'h0, rd);
		chk("control reset", 32'hf000, rd);
		ahb(1'b1, `BSC_CTRL_ADDR, 32'hffffffff, rd);
		ahb(1'b0, `BSC_CTRL_ADDR, 32'h0, rd);
		chk("control reserved", 32'hf006, rd);
		ahb(1'b1, 32'ha8, 32'h1234, rd);
		ahb(1'b0, 32'ha8, 32'h0, rd);
		chk("unmapped read", 32'h0, rd);
		$display("Register test done");
		wreg(16'h6000);
		acc(BSC_SP_PROG, 1'b1, 18'h00010, 16'h1357);
		acc(BSC_SP_PROG, 1'b0, 18'h00011, 16'h0);
		acc(BSC_SP_PROG, 1'b0, 18'h08000, 16'h0);
		acc(BSC_SP_DATA, 1'b0, 18'h08001, 16'h0);
		acc(BSC_SP_PROG, 1'b0, 18'h08002, 16'h0);
		acc(BSC_SP_DATA, 1'b1, 18'h3ffff, 16'hbeef);
		acc(BSC_SP_IO, 1'b0, 18'h3ffff, 16'h0);
		acc(BSC_SP_IO, 1'b1, 18'h00000, 16'h4242);
		wreg(16'he000);
		acc(BSC_SP_DATA, 1'b0, 18'h3fff0, 16'h0);
		acc(BSC_SP_DATA, 1'b0, 18'h3fff1, 16'h0);
		$display("Bank switch test done");
		for (int f = 0; f < 4; f++)
		begin
			seed = lfsr(seed);
			wreg({seed[3], f[1:0], 13'h0});
			repeat (2) @(posedge clk);
			if (f == 0)
			begin
				n = 0;
				repeat (8) @(posedge clk) n += oclk;
				chk("output clock held", 8, n);
			end
			else
			begin
				while (oclk !== 1'b0) @(posedge clk);
				while (oclk !== 1'b1) @(posedge clk);
				n = 0;
				do begin @(posedge clk); n++; end while (oclk !== 1'b0);
				do begin @(posedge clk); n++; end while (oclk !== 1'b1);
				chk("output clock period", f + 1, n);
			end
			repeat (8)
			begin
				seed = lfsr(seed);
				acc((seed[1:0] == 2'h3) ? BSC_SP_PROG : bsc_space_t'(seed[1:0]), seed[2], seed[20:3],
					seed[31:16]);
			end
		end
		$display("Divider and random access test done");
		for (int b = 0; b < 2; b++)
		begin
			wreg({3'h0, b[0], 12'h0});
			@(posedge clk) int_ack <= 1'b1;
			@(posedge clk) int_ack <= 1'b0;
			@(posedge clk);
			chk("interrupt acknowledge", {31'h0, b[0]}, {31'h0, interrupt_acknowledge_out_n});
		end
		$display("Acknowledge test done");
		for (int k = 0; k < 8; k++)
		begin
			wreg({13'h0, k[1:0], 1'b0});
			strap <= k[2];
			repeat (3) @(posedge clk);
			chk("keepers", {29'h0, k[1] & k[2], k[0], k[1] | k[2]}, {29'h0, akeep, dkeep, hkeep});
		end
		$display("Keeper test done");
		end_of_test();
	end
endmodule : bank_switch_bus_control_tb
